/* File: hw/mv_limit_and_fallback.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "mv_limit_defs.svh"
// Notes on behaviour
// - Standard control clamps output between both bounds.
// - Heating/cooling: upper bound limits heating side.
// - Heating/cooling: lower bound limits cooling side.
// - Limiting only under PID; limited value output.
// - Upper bound resets 1000, accepts -50..1050 (0..1050 under heating/cooling).
// - Lower above upper: upper used as lower.
// - Bound writes take effect at once.
// - Bus or watchdog error triggers fallback output.
// - Coupler link failure also triggers fallback.
// - Link-loss fallback only under PID control.
// - Sensor fault drives the sensor-fault value.
// - Link-loss value outranks sensor-fault value.
// - Selector: 0 continue control, 1 preset value.
// - Operator value also clamped to bounds.
module mv_limit_and_fallback (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire mv_limit_pkg::mv_bus_type  pid_mv,
  input  wire logic [`NUM_CH-1:0]        sensor_fault,
  input  wire logic                      bus_error,
  input  wire logic                      host_wdt_error,
  input  wire logic                      coupler_link_error,
  output mv_limit_pkg::mv_bus_type       mv_out,
  output logic                           link_lost,
  output logic                           irq
);
  // ========================================================================
  // Declarations.
  mv_limit_pkg::core_state_type state_ff;   // All state of the block but the bus read data.
  mv_limit_pkg::core_state_type nxt_state;  // Its next value.
  mv_limit_pkg::apb_req_type    req;        // Bundled bus request.
  mv_limit_pkg::apb_dec_type    dec;        // Decoded bus phases.
  mv_limit_pkg::mv_bus_type     clamp_in;   // Value handed to each clamp.
  mv_limit_pkg::mv_bus_type     clamp_out;  // Clamped value per channel.
  mv_limit_pkg::ch_cfg_type     rcfg;       // Channel picked for readback.
  mv_limit_pkg::mv_type         wv;         // Write data as a value.
  logic [`ST_W-1:0]             events;     // Sticky status set terms.
  logic [`ST_W-1:0]             w1c;        // Status clear terms.
  logic [`NUM_CH-1:0]           rng;        // Refused out-of-range write.
  logic [31:0]                  rd_word;    // Read data for the slave.
  logic                         link_now;   // Host settings not arriving.
  logic                         ch_hit;     // Address hits a channel word.
  logic                         glb_hit;    // Address hits a global word.
  logic                         addr_hit;   // Any mapped word.
  logic                         sel_ch;     // Channel index from address.
  logic [4:0]                   off;        // Offset inside a channel.

  // ========================================================================
  // Bus front end.
  // Zero wait states: every access ends at once.
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  apb_access u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (req),
    .addr_hit (addr_hit),
    .rd_word  (rd_word),
    .dec      (dec),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // ========================================================================
  // One clamp per channel; they run every cycle, so every control update
  // sees bounds as they stand in that very cycle.
  // A bound written now is used from the next edge.
  for (genvar g = 0; g < `NUM_CH; g++) begin : g_clamp
    mv_clamp u_clamp (
      .value_in   (clamp_in[g]),
      .high_bound (state_ff.cfg[g].high),
      .low_bound  (state_ff.cfg[g].low),
      .value_out  (clamp_out[g])
    );
  end

  // ========================================================================
  // Address decode; channel words below 0x40, globals at 0x40..0x48.
  // Bit 5 picks the channel, bits 4:0 the word.
  // Anything else is unmapped and gets a slave error.
  always_comb begin
    sel_ch  = paddr[`CH_BIT];
    off     = paddr[4:0];
    ch_hit  = (paddr[7:6] == 2'h0) && (off <= `OFF_MV) && (paddr[1:0] == 2'h0);
    glb_hit = (paddr == `OFF_STATUS) || (paddr == `OFF_MASK) ||
              (paddr == `OFF_LINKST);
    addr_hit = ch_hit | glb_hit;
  end

  // ========================================================================
  // Read multiplexer; narrow fields sit in the low bits, the rest is zero.
  // Values come back zero-extended; software sign-extends.
  always_comb begin
    rd_word = 32'h0000_0000;
    rcfg    = state_ff.cfg[sel_ch];
    if (ch_hit) begin
      if (off == `OFF_CTRL) begin
        rd_word = {28'h000_0000, rcfg.ctrl};
      end else if (off == `OFF_HIGH) begin
        rd_word = {16'h0000, rcfg.high};
      end else if (off == `OFF_LOW) begin
        rd_word = {16'h0000, rcfg.low};
      end else if (off == `OFF_FAULT) begin
        rd_word = {16'h0000, rcfg.fault};
      end else if (off == `OFF_LINK) begin
        rd_word = {16'h0000, rcfg.link};
      end else if (off == `OFF_OPER) begin
        rd_word = {16'h0000, rcfg.oper};
      end else if (off == `OFF_MV) begin
        rd_word = {16'h0000, state_ff.mv[sel_ch]};
      end
    end else if (paddr == `OFF_STATUS) begin
      rd_word = {27'h000_0000, state_ff.status};
    end else if (paddr == `OFF_MASK) begin
      rd_word = {27'h000_0000, state_ff.mask};
    end else if (paddr == `OFF_LINKST) begin
      rd_word = {31'h0000_0000, state_ff.link_prev};
    end
  end

  // ========================================================================
  // Next-state logic: register writes, fallback selection and status.
  // Ranges use the control type as it stands at the write.
  // A bad value is refused, not clipped, so software notices.
  always_comb begin
    nxt_state = state_ff;
    wv        = pwdata[15:0];
    events    = '0;
    w1c       = '0;
    rng       = '0;
    clamp_in  = '0;
    // Any of the three link faults means settings from the host stop.
    link_now = bus_error | host_wdt_error | coupler_link_error;
    events[`ST_LINK] = link_now & ~state_ff.link_prev;
    nxt_state.link_prev  = link_now;
    nxt_state.fault_prev = sensor_fault;
    // Global writes: status is write-one-to-clear, mask is plain.
    if (dec.wr && (paddr == `OFF_STATUS)) begin
      w1c = pwdata[`ST_W-1:0];
    end else if (dec.wr && (paddr == `OFF_MASK)) begin
      nxt_state.mask = pwdata[`ST_W-1:0];
    end
    for (int c = 0; c < `NUM_CH; c++) begin
      events[`ST_FAULT0 + c] = sensor_fault[c] & ~state_ff.fault_prev[c];
      // Channel writes land in the next cycle's state, no restart needed.
      // An out-of-range value is refused whole and flagged in status.
      if (dec.wr && ch_hit && (sel_ch == 1'(c))) begin
        if (off == `OFF_CTRL) begin
          nxt_state.cfg[c].ctrl = pwdata[`CTRL_W-1:0];
        end else if (off == `OFF_HIGH) begin
          if (mv_limit_pkg::in_range(wv, state_ff.cfg[c].ctrl[`CTRL_HC] ?
              `RST_ZERO : `STD_MIN, `ANY_MAX)) begin
            nxt_state.cfg[c].high = wv;
          end else begin
            rng[c] = 1'b1;
          end
        end else if (off == `OFF_LOW) begin
          if (mv_limit_pkg::in_range(wv, state_ff.cfg[c].ctrl[`CTRL_HC] ?
              `HC_MIN : `STD_MIN, state_ff.cfg[c].ctrl[`CTRL_HC] ?
              `RST_ZERO : `ANY_MAX)) begin
            nxt_state.cfg[c].low = wv;
          end else begin
            rng[c] = 1'b1;
          end
        end else if (off == `OFF_FAULT) begin
          if (mv_limit_pkg::value_ok(state_ff.cfg[c].ctrl[`CTRL_HC], wv)) begin
            nxt_state.cfg[c].fault = wv;
          end else begin
            rng[c] = 1'b1;
          end
        end else if (off == `OFF_LINK) begin
          if (mv_limit_pkg::value_ok(state_ff.cfg[c].ctrl[`CTRL_HC], wv)) begin
            nxt_state.cfg[c].link = wv;
          end else begin
            rng[c] = 1'b1;
          end
        end else if (off == `OFF_OPER) begin
          if (mv_limit_pkg::value_ok(state_ff.cfg[c].ctrl[`CTRL_HC], wv)) begin
            nxt_state.cfg[c].oper = wv;
          end else begin
            rng[c] = 1'b1;
          end
        end
      end
      events[`ST_RANGE0 + c] = rng[c];
      // Manual mode feeds the operator value through the same clamp.
      clamp_in[c] = state_ff.cfg[c].ctrl[`CTRL_MAN] ?
                    state_ff.cfg[c].oper : pid_mv[c];
      // Output selection, highest priority first. Outside PID control the
      // computed value passes untouched and no fallback applies.
      // Fallback values go out unclamped, as the host set them.
      if (!state_ff.cfg[c].ctrl[`CTRL_PID]) begin
        nxt_state.mv[c] = pid_mv[c];
      end else if (link_now && state_ff.cfg[c].ctrl[`CTRL_LSEL]) begin
        nxt_state.mv[c] = state_ff.cfg[c].link;
      end else if (sensor_fault[c]) begin
        nxt_state.mv[c] = state_ff.cfg[c].fault;
      end else begin
        nxt_state.mv[c] = clamp_out[c];
      end
    end
    // A new event wins over a clear in the same cycle.
    nxt_state.status = (state_ff.status & ~w1c) | events;
  end

  // ========================================================================
  // State register; bounds come out of reset for standard control.
  // Only control and upper bound reset to non-zero values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
      for (int c = 0; c < `NUM_CH; c++) begin
        state_ff.cfg[c].ctrl <= `RST_CTRL;
        state_ff.cfg[c].high <= `RST_HIGH;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Outputs, all from flops; the interrupt is a level over masked status.
  // Sticky status keeps a one-cycle event from being lost.
  assign mv_out    = state_ff.mv;
  assign link_lost = state_ff.link_prev;
  assign irq       = |(state_ff.status & state_ff.mask);

  // ========================================================================
  // Checks on channel 0; the other channels share the same logic.
  // Each property is sampled on the rising clock edge.
  // Helper terms below feed the assertions only.
  mv_limit_pkg::ch_cfg_type cfg0;   // Channel 0 settings.
  logic                     pid0;   // Channel 0 under PID control.
  logic                     fb0;    // Channel 0 on link-loss value.
  logic                     norm0;  // Channel 0 on the clamp path.
  assign cfg0  = state_ff.cfg[0];
  assign pid0  = cfg0.ctrl[`CTRL_PID];
  assign fb0   = pid0 & link_now & cfg0.ctrl[`CTRL_LSEL];
  assign norm0 = pid0 & ~fb0 & ~sensor_fault[0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A write to the channel 0 upper bound that completes this cycle.
  sequence s_wr_high0;
    dec.wr && (paddr == {3'h0, `OFF_HIGH});
  endsequence
  // Such a write carrying a standard-control value out of range.
  sequence s_bad_high0;
    s_wr_high0 ##0 (!cfg0.ctrl[`CTRL_HC] &&
      !mv_limit_pkg::in_range(wv, `STD_MIN, `ANY_MAX));
  endsequence

  chk_clamp_upper: assert property (
    norm0 && !cfg0.ctrl[`CTRL_MAN] && ($signed(pid_mv[0]) > cfg0.high)
    |=> $signed(mv_out[0]) == $past(cfg0.high))
    else $error("output above upper bound not clamped");
  chk_clamp_lower: assert property (
    norm0 && !cfg0.ctrl[`CTRL_MAN] && (cfg0.low <= cfg0.high) &&
    ($signed(pid_mv[0]) < cfg0.low)
    |=> $signed(mv_out[0]) == $past(cfg0.low))
    else $error("output below lower bound not clamped");
  chk_heat_side: assert property (
    norm0 && cfg0.ctrl[`CTRL_HC]
    |=> $signed(mv_out[0]) <= $past(cfg0.high))
    else $error("heating side exceeds upper bound");
  chk_cool_side: assert property (
    norm0 && cfg0.ctrl[`CTRL_HC] && (cfg0.low <= cfg0.high)
    |=> $signed(mv_out[0]) >= $past(cfg0.low))
    else $error("cooling side exceeds lower bound");
  chk_no_pid_bypass: assert property (
    !pid0 |=> mv_out[0] == $past(pid_mv[0]))
    else $error("output altered outside PID control");
  chk_range_reject: assert property (
    s_bad_high0 |=> (cfg0.high == $past(cfg0.high)) && state_ff.status[`ST_RANGE0])
    else $error("out-of-range upper bound not refused");
  chk_bound_invert: assert property (
    norm0 && !cfg0.ctrl[`CTRL_MAN] && (cfg0.low > cfg0.high)
    |=> $signed(mv_out[0]) == $past(cfg0.high))
    else $error("inverted bounds not resolved to upper");
  chk_write_now: assert property (
    s_wr_high0 ##0 mv_limit_pkg::in_range(wv, `STD_MIN, `ANY_MAX) ##0
    !cfg0.ctrl[`CTRL_HC] |=> cfg0.high == $past(wv))
    else $error("upper bound write not applied at once");
  chk_link_fallback: assert property (
    fb0 |=> mv_out[0] == $past(cfg0.link))
    else $error("link-loss value not driven");
  chk_coupler_loss: assert property (
    pid0 && cfg0.ctrl[`CTRL_LSEL] && coupler_link_error
    ##1 pid0 && cfg0.ctrl[`CTRL_LSEL] && coupler_link_error
    |=> mv_out[0] == $past(cfg0.link))
    else $error("coupler failure did not select link-loss value");
  chk_pid_only_fb: assert property (
    !pid0 && link_now |=> mv_out[0] == $past(pid_mv[0]))
    else $error("fallback applied outside PID control");
  chk_fault_value: assert property (
    pid0 && !fb0 && sensor_fault[0] |=> mv_out[0] == $past(cfg0.fault))
    else $error("sensor-fault value not driven");
  chk_link_priority: assert property (
    fb0 && sensor_fault[0] |=> mv_out[0] == $past(cfg0.link))
    else $error("sensor-fault value beat link-loss value");
  chk_link_continue: assert property (
    pid0 && link_now && !cfg0.ctrl[`CTRL_LSEL] && !sensor_fault[0]
    |=> mv_out[0] == $past(clamp_out[0]))
    else $error("selector 0 did not continue control");
  chk_manual_clamp: assert property (
    norm0 && cfg0.ctrl[`CTRL_MAN] && (cfg0.oper > cfg0.high)
    |=> $signed(mv_out[0]) == $past(cfg0.high))
    else $error("operator value not clamped");
  chk_sticky_set: assert property (
    pid0 && sensor_fault[0] && !state_ff.fault_prev[0]
    |=> state_ff.status[`ST_FAULT0] [*2])
    else $error("sensor fault event lost");
  // A rising link fault is latched in status.
  chk_link_event: assert property (
    link_now && !state_ff.link_prev |=> state_ff.status[`ST_LINK])
    else $error("link loss event not latched");
  // The link flag follows the faults one cycle late.
  chk_link_flag: assert property (
    link_now |=> link_lost)
    else $error("link lost flag not raised");
  // Writing one clears a range flag not raised anew.
  chk_range_clear: assert property (
    dec.wr && (paddr == `OFF_STATUS) && pwdata[`ST_RANGE0] && !rng[0]
    |=> !state_ff.status[`ST_RANGE0])
    else $error("range flag not cleared");
endmodule : mv_limit_and_fallback

/* File: hw/mv_limit_defs.svh */
`ifndef MV_LIMIT_DEFS_SVH
`define MV_LIMIT_DEFS_SVH
// ==========================================================================
// Geometry.
`define NUM_CH      2
`define MV_W        16
`define CTRL_W      4
`define ST_W        5
// ==========================================================================
// Per-channel register offsets; channel c sits at byte address 32*c.
`define OFF_CTRL    5'h00
`define OFF_HIGH    5'h04
`define OFF_LOW     5'h08
`define OFF_FAULT   5'h0C
`define OFF_LINK    5'h10
`define OFF_OPER    5'h14
`define OFF_MV      5'h18
`define CH_BIT      5
// Global registers.
`define OFF_STATUS  8'h40
`define OFF_MASK    8'h44
`define OFF_LINKST  8'h48
// ==========================================================================
// Control field positions.
`define CTRL_PID    0
`define CTRL_HC     1
`define CTRL_MAN    2
`define CTRL_LSEL   3
// Status field positions.
`define ST_LINK     0
`define ST_FAULT0   1
`define ST_RANGE0   3
// ==========================================================================
// Reset values: control word, then bound values in units of 0.1 percent.
`define RST_CTRL    4'h1
`define RST_HIGH    16'h03E8
`define RST_ZERO    16'h0000
// Accepted ranges: -50, 1050 and -1050 in units of 0.1 percent.
`define STD_MIN     16'hFFCE
`define ANY_MAX     16'h041A
`define HC_MIN      16'hFBE6
`endif

/* File: hw/mv_limit_pkg.sv */
`include "mv_limit_defs.svh"
// ==========================================================================
// Types and shared arithmetic of the output limiting stage.
package mv_limit_pkg;
  typedef logic signed [`MV_W-1:0] mv_type;        // Output value, 0.1 percent.
  typedef mv_type [`NUM_CH-1:0]    mv_bus_type;    // One value per channel.
  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;                      // Mode and selector bits.
    mv_type             high;                      // Upper bound.
    mv_type             low;                       // Lower bound.
    mv_type             fault;                     // Sensor-fault value.
    mv_type             link;                      // Link-loss value.
    mv_type             oper;                      // Operator value.
  } ch_cfg_type;
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_type;
  typedef struct packed {
    logic setup;                                   // First cycle of a transfer.
    logic access;                                  // Completing cycle.
    logic wr;                                      // Write that takes effect.
  } apb_dec_type;
  typedef struct packed {
    logic [31:0] prdata;
  } apb_state_type;
  typedef struct packed {
    ch_cfg_type [`NUM_CH-1:0] cfg;
    mv_bus_type               mv;
    logic [`ST_W-1:0]         status;
    logic [`ST_W-1:0]         mask;
    logic                     link_prev;
    logic [`NUM_CH-1:0]       fault_prev;
  } core_state_type;
  // True when v lies in [lo, hi], signed.
  function automatic logic in_range(mv_type v, mv_type lo, mv_type hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range
  // Range of an output value for the selected control type.
  function automatic logic value_ok(logic hc, mv_type v);
    return in_range(v, hc ? `HC_MIN : `STD_MIN, `ANY_MAX);
  endfunction : value_ok
endpackage : mv_limit_pkg

/* File: hw/mv_clamp.sv */
`timescale 1ns/1ps
// ==========================================================================
// Combinational clamp; an inverted pair of bounds collapses onto the upper.
module mv_clamp (
  input  wire mv_limit_pkg::mv_type value_in,
  input  wire mv_limit_pkg::mv_type high_bound,
  input  wire mv_limit_pkg::mv_type low_bound,
  output mv_limit_pkg::mv_type      value_out
);
  mv_limit_pkg::mv_type eff_low;   // Lower bound as used by control.

  // The upper bound wins over a larger lower bound.
  always_comb begin
    eff_low = (low_bound > high_bound) ? high_bound : low_bound;
    if (value_in > high_bound) begin
      value_out = high_bound;
    end else if (value_in < eff_low) begin
      value_out = eff_low;
    end else begin
      value_out = value_in;
    end
  end
endmodule : mv_clamp

/* File: hw/apb_access.sv */
`timescale 1ns/1ps
// ==========================================================================
// APB slave front end: zero wait states, read data captured at setup.
module apb_access (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire mv_limit_pkg::apb_req_type  req,
  input  wire logic                       addr_hit,
  input  wire logic [31:0]                rd_word,
  output mv_limit_pkg::apb_dec_type       dec,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr
);
  mv_limit_pkg::apb_state_type state_ff;   // Registered read data.
  mv_limit_pkg::apb_state_type nxt_state;  // Its next value.

  // Read data is taken in the setup cycle, so prdata comes from a flop
  // yet no wait state is needed; the value is the one seen at setup.
  always_comb begin
    nxt_state  = state_ff;
    dec.setup  = req.sel & ~req.enable;
    dec.access = req.sel & req.enable;
    dec.wr     = dec.access & req.write & addr_hit;
    if (dec.setup && !req.write) begin
      nxt_state.prdata = addr_hit ? rd_word : 32'h0000_0000;
    end
    pready  = 1'b1;
    pslverr = dec.access & ~addr_hit;
    prdata  = state_ff.prdata;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : apb_access

/* File: bench/host_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Host controller: an APB master that issues one transfer per task call.
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // The bus idles with no select, so nothing reaches the slave before use.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Setup, then access held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data shows its inverse so a stale word is never mistaken.
    pwdata <= ~d;
  endtask : xfer
endmodule : host_model

/* File: bench/tb_mv_limit_and_fallback.sv */
`timescale 1ns/1ps
// ==========================================================================
// Bench for the output limiting stage; ordinary cases run from a table.
module tb_mv_limit_and_fallback;
  typedef struct packed {
    logic [3:0]           c;            // Control word.
    mv_limit_pkg::mv_type h;            // Upper bound.
    mv_limit_pkg::mv_type l;            // Lower bound.
    mv_limit_pkg::mv_type p;            // Computed input.
    mv_limit_pkg::mv_type e;            // Expected output.
  } row_type;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel, penable, pwrite, pready, pslverr, link_lost, irq;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rdat;
  logic                     err;
  mv_limit_pkg::mv_bus_type pid_mv = '0;
  mv_limit_pkg::mv_bus_type mv_out;
  logic [1:0]               sensor_fault = 2'b00;
  logic [2:0]               lnk = 3'b000;      // Bus, watchdog, coupler errors.
  int                       mismatches = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;
  // Each row: clamp above, below, inside, inverted bounds, both sides, PID off.
  row_type rows [7] = '{
    '{4'h1, 16'h03E8, 16'h0000, 16'h04B0, 16'h03E8},
    '{4'h1, 16'h03E8, 16'h0000, 16'hFFE2, 16'h0000},
    '{4'h1, 16'h03E8, 16'h0000, 16'h01F4, 16'h01F4},
    '{4'h1, 16'h03E8, 16'h041A, 16'h01F4, 16'h03E8},
    '{4'h3, 16'h0320, 16'hFDA8, 16'hFC7C, 16'hFDA8},
    '{4'h3, 16'h0320, 16'hFDA8, 16'h0384, 16'h0320},
    '{4'h0, 16'h03E8, 16'h0000, 16'h04B0, 16'h04B0}};
  mv_limit_and_fallback uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pid_mv(pid_mv),
    .sensor_fault(sensor_fault), .bus_error(lnk[2]), .host_wdt_error(lnk[1]),
    .coupler_link_error(lnk[0]), .mv_out(mv_out), .link_lost(link_lost), .irq(irq));
  host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ========================================================================
  // Clock and hang guard; the whole run needs well under the ceiling.
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      close_out();
    end
  end
  // ========================================================================
  // Shared helpers for comparison, bus transfers and output settling.
  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s at %0t: seen %h, wanted %h", m, $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h00000000, rdat, err);
  endtask : rd
  // Output is registered, so two edges cover the write and the update.
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ========================================================================
  // Main sequence: reset, table, then the awkward cases by hand.
  initial begin
    repeat (4) @(posedge pclk);
    check({irq, link_lost, 14'h0000, mv_out[0]}, 32'h00000000, "reset outputs");
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04);
    check(rdat, 32'h000003E8, "upper reset");
    check({31'h00000000, err}, 32'h00000000, "mapped read");
    foreach (rows[i]) begin
      wr(8'h00, {28'h0000000, rows[i].c});
      wr(8'h04, {16'h0000, rows[i].h});
      wr(8'h08, {16'h0000, rows[i].l});
      pid_mv <= {16'h01F4, rows[i].p};
      settle();
      check(32'(mv_out[0]), 32'(rows[i].e), "table");
    end
    check(32'(mv_out[1]), 32'h000001F4, "channel one");
    // An out-of-range bound is refused and raises the masked interrupt.
    wr(8'h44, 32'h00000008);
    wr(8'h04, 32'h0000041B);
    rd(8'h04);
    check(rdat, 32'h000003E8, "refused bound");
    check({31'h00000000, irq}, 32'h00000001, "irq set");
    wr(8'h40, 32'h00000008);
    settle();
    check({31'h00000000, irq}, 32'h00000000, "irq clear");
    wr(8'h04, 32'h0000FFCE);
    rd(8'h04);
    check(rdat, 32'h0000FFCE, "lowest bound");
    rd(8'hFC);
    check({31'h00000000, err}, 32'h00000001, "unmapped");
    // Operator value is clamped like the computed one.
    wr(8'h14, 32'h0000041A);
    wr(8'h04, 32'h00000384);
    wr(8'h00, 32'h00000005);
    settle();
    check(32'(mv_out[0]), 32'h00000384, "manual");
    wr(8'h0C, 32'h0000004D);
    @(posedge pclk);
    sensor_fault <= 2'b01;
    settle();
    check(32'(mv_out[0]), 32'h0000004D, "sensor fault");
    rd(8'h40);
    check(rdat, 32'h00000002, "fault event");
    // Each link error alone brings the preset value ahead of the fault one.
    wr(8'h10, 32'h0000014D);
    wr(8'h00, 32'h00000009);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      lnk <= 3'b100 >> i;
      settle();
      check(32'(mv_out[0]), 32'h0000014D, "link value");
      check({31'h00000000, link_lost}, 32'h00000001, "link lost");
    end
    rd(8'h48);
    check(rdat, 32'h00000001, "link word");
    wr(8'h00, 32'h00000001);
    settle();
    check(32'(mv_out[0]), 32'h0000004D, "selector zero");
    @(posedge pclk);
    sensor_fault <= 2'b00;
    settle();
    check(32'(mv_out[0]), 32'h00000384, "control goes on");
    wr(8'h00, 32'h00000008);
    settle();
    check(32'(mv_out[0]), 32'h000004B0, "no pid");
    close_out();
  end
endmodule : tb_mv_limit_and_fallback
